//--- core/digital_io_pattern_interrupt.sv
// digital i/o block: bit port, byte port, mask/compare and digital irq
// Behaviour
// RQ1: bit port lines each set input (0) or output (1) by direction bit.
// RQ2: bit port input lines read pins; host writes do not affect them.
// RQ3: bit port output lines drive written value; reads return driven value.
// RQ4: any digital reset makes lines inputs and clears output registers.
// RQ5: byte port has one direction; input reads pins, output drives writes.
// RQ6: mode bits 1:0 steer control address: clear/reset, dir, mask, compare.
// RQ7: mask bit 1 excludes that bit port line from pattern monitoring.
// RQ8: without irq modes, masked output lines hold level despite writes.
// RQ9: match mode raises irq when unmasked lines equal compare pattern.
// RQ10: software selects match mode before writing the compare pattern.
// RQ11: event mode raises irq on unmasked change, latching port into compare.
// RQ12: mode/status read gives irq in bit 6, strobe in bit 7, config 5:0.
// RQ13: mode bit 2 sets byte port direction, 0 input, 1 output.
// RQ14: mode bit 3 picks event/match; bit 4 enables the digital irq.
// RQ15: mode bit 5 picks fixed or programmable input sample clock.
// RQ16: irq flag stays set until clear read or digital reset.
`timescale 1ns/1ps
`default_nettype none
`include "dio_defs.svh"
module digital_io_pattern_interrupt (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // host register port
   input wire logic [8:0] addr,
   input wire logic rd_stb,
   input wire logic wr_stb,
   input wire logic [31:0] wr_data,
   output logic [31:0] rd_data,
   // bit programmable port
   input wire logic [7:0] bitwise_port_in,
   output logic [7:0] bitwise_port_out,
   output logic [7:0] bitwise_port_oe,
   // byte programmable port
   input wire logic [7:0] bytewide_port_in,
   output logic [7:0] bytewide_port_out,
   output logic [7:0] bytewide_port_oe,
   // sampling strobes and status
   input wire logic fixed_sample_tick,
   input wire logic prog_sample_tick,
   input wire logic strobe_in,
   output logic digital_irq
);
   import dio_pkg::*;

   // ==========================================================
   // storage
   byte_t dir_r, mask_r, cmp_r, bit_out_r, byte_out_r, samp_r;
   logic [5:0] mode_r;
   logic irq_r, strobe_r, samp_valid_r, byte_oe_r;
   logic [31:0] rd_data_r;

   // ==========================================================
   // decode
   // one strobe on the control address, steered by the window select
   function automatic logic ctl_access(input logic stb, input logic hit,
                                       input ctl_sel_t cur,
                                       input ctl_sel_t want);
      return stb && (hit && (cur == want));
   endfunction : ctl_access

   wire sel_bit = addr == `OFS_BIT_PORT_DATA;
   wire sel_byte = addr == `OFS_BYTE_PORT_DATA;
   wire sel_ctl = addr == `OFS_BIT_PORT_CONTROL_WINDOW;
   wire sel_mode = addr == `OFS_DIGITAL_MODE_AND_STATUS;
   ctl_sel_t csel;
   assign csel = ctl_sel_t'(mode_r[`MODE_SEL_MSB:`MODE_SEL_LSB]); // see RQ6
   wire match_mode = mode_r[`MODE_MATCH_BIT]; // see RQ14
   wire irq_en = mode_r[`MODE_IRQ_EN_BIT]; // see RQ14
   wire byte_dir = mode_r[`MODE_BYTE_DIR_BIT]; // see RQ13
   wire dio_reset = ctl_access(wr_stb, sel_ctl, csel, SEL_CLEAR); // see RQ6
   wire irq_clear = ctl_access(rd_stb, sel_ctl, csel, SEL_CLEAR); // see RQ16
   wire wr_dir = ctl_access(wr_stb, sel_ctl, csel, SEL_DIR); // see RQ1
   wire wr_mask = ctl_access(wr_stb, sel_ctl, csel, SEL_MASK); // see RQ7
   wire wr_cmp = ctl_access(wr_stb, sel_ctl, csel, SEL_CMP); // see RQ9
   wire wr_bit = wr_stb && sel_bit;
   wire wr_byte = wr_stb && sel_byte && byte_dir; // see RQ5
   wire wr_mode = wr_stb && sel_mode;
   wire rd_mode = rd_stb && sel_mode;

   // ==========================================================
   // pin view
   // normal mode: masked output bits keep their level
   wire [7:0] keep = irq_en ? 8'h00 : mask_r; // see RQ8
   wire [7:0] bit_view;
   wire [7:0] bit_nxt;
   // one slice per line, each under its own direction bit
   for (genvar i = 0; i < 8; i++) begin : g_line
      // driven value on outputs, pin level on inputs
      assign bit_view[i] = dir_r[i] ? bit_out_r[i]
                                    : bitwise_port_in[i]; // see RQ1 RQ2
      // input lines and held lines ignore the write data
      assign bit_nxt[i] = (dir_r[i] && !keep[i]) ? wr_data[i]
                                                 : bit_out_r[i]; // see RQ3
   end

   // ==========================================================
   // pattern monitor
   // sample clock choice gates when the monitor looks at the port
   wire samp_tick = mode_r[`MODE_CLK_SEL_BIT] ? prog_sample_tick
                                             : fixed_sample_tick; // see RQ15
   wire [7:0] watch = ~mask_r; // see RQ7
   wire hit_match = samp_tick &&
                    ((bit_view & watch) == (cmp_r & watch)); // see RQ9
   // the first tick after a reset only primes the history
   wire hit_event = samp_tick && samp_valid_r &&
                    (((bit_view ^ samp_r) & watch) != 8'h00); // see RQ11
   wire irq_set = irq_en && (match_mode ? hit_match : hit_event);

   // ==========================================================
   // read data
   wire [31:0] ctl_rd = csel == SEL_DIR ? {24'h0, dir_r} :
                        csel == SEL_MASK ? {24'h0, mask_r} :
                        csel == SEL_CMP ? {24'h0, cmp_r} : 32'h0;
   wire [7:0] byte_view = byte_dir ? byte_out_r : bytewide_port_in; // see RQ5
   wire [31:0] mode_rd = {24'h0, strobe_r, irq_r, mode_r}; // see RQ12
   wire [31:0] rd_nxt = sel_bit ? {24'h0, bit_view} : // see RQ2 RQ3
                        sel_byte ? {24'h0, byte_view} :
                        sel_ctl ? ctl_rd :
                        sel_mode ? mode_rd :
                        32'h0;

   // ==========================================================
   // port registers
   // writes to input lines, or to the byte port as input, drop quietly
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dir_r <= `RST_BYTE;
         mask_r <= `RST_MASK;
         bit_out_r <= `RST_BYTE;
         byte_out_r <= `RST_BYTE;
      end else if (dio_reset) begin
         dir_r <= `RST_BYTE; // see RQ4
         bit_out_r <= `RST_BYTE; // see RQ4
         byte_out_r <= `RST_BYTE; // see RQ4
         mask_r <= `RST_MASK;
      end else begin
         if (wr_bit)
            bit_out_r <= bit_nxt; // see RQ2 RQ3
         if (wr_byte)
            byte_out_r <= wr_data[7:0]; // see RQ5
         if (wr_dir)
            dir_r <= wr_data[7:0]; // see RQ1
         if (wr_mask)
            mask_r <= wr_data[7:0]; // see RQ7
      end
   end

   // compare register: host pattern, or captured value in event mode
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         cmp_r <= `RST_BYTE;
      else if (dio_reset)
         cmp_r <= `RST_BYTE;
      else if (irq_set && !match_mode)
         cmp_r <= bit_view; // see RQ11
      else if (wr_cmp)
         cmp_r <= wr_data[7:0]; // see RQ9
   end

   // ==========================================================
   // change history
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         samp_r <= `RST_BYTE;
         samp_valid_r <= `RST_FLAG;
      end else if (dio_reset) begin
         samp_valid_r <= `RST_FLAG;
      end else if (samp_tick) begin
         samp_r <= bit_view;
         samp_valid_r <= 1'b1;
      end
   end

   // ==========================================================
   // mode register
   // the window select survives a digital reset so the clear path stays
   // reachable; only the byte direction falls back to input
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         mode_r <= `RST_MODE;
      else if (wr_mode)
         mode_r <= wr_data[5:0]; // see RQ13 RQ14 RQ15
      else if (dio_reset)
         mode_r[`MODE_BYTE_DIR_BIT] <= 1'b0; // see RQ4
   end

   // ==========================================================
   // flags
   // a set in the clearing cycle wins, so no event is lost
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_r <= `RST_FLAG;
         strobe_r <= `RST_FLAG;
      end else begin
         irq_r <= irq_set | (irq_r & ~irq_clear & ~dio_reset); // see RQ16
         strobe_r <= strobe_in | (strobe_r & ~rd_mode & ~dio_reset);
      end
   end

   // ==========================================================
   // read data register
   // held until the next read, so a slow poll sees a steady word
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_r <= `RST_WORD;
         byte_oe_r <= `RST_FLAG;
      end else begin
         rd_data_r <= rd_stb ? rd_nxt : rd_data_r;
         byte_oe_r <= byte_dir && !dio_reset;
      end
   end

   // ==========================================================
   // outputs
   // every output leaves straight from a flop
   assign rd_data = rd_data_r;
   assign bitwise_port_out = bit_out_r;
   assign bitwise_port_oe = dir_r; // see RQ1
   assign bytewide_port_out = byte_out_r;
   assign bytewide_port_oe = {8{byte_oe_r}}; // see RQ13
   assign digital_irq = irq_r;
endmodule : digital_io_pattern_interrupt
`default_nettype wire

//--- core/dio_defs.svh
// register offsets, field positions and reset values of the digital i/o block
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH
`define OFS_BIT_PORT_DATA 9'h070
`define OFS_BYTE_PORT_DATA 9'h074
`define OFS_BIT_PORT_CONTROL_WINDOW 9'h078
`define OFS_DIGITAL_MODE_AND_STATUS 9'h07c
`define MODE_SEL_LSB 0
`define MODE_SEL_MSB 1
`define MODE_BYTE_DIR_BIT 2
`define MODE_MATCH_BIT 3
`define MODE_IRQ_EN_BIT 4
`define MODE_CLK_SEL_BIT 5
`define STAT_IRQ_BIT 6
`define STAT_STROBE_BIT 7
`define RST_BYTE 8'h00
`define RST_MODE 6'h00
`define RST_MASK 8'h00
`define RST_FLAG 1'b0
`define RST_WORD 32'h00000000
`endif

//--- core/dio_pkg.sv
// types shared by the digital i/o block
package dio_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [1:0] {
      SEL_CLEAR = 2'b00,
      SEL_DIR = 2'b01,
      SEL_MASK = 2'b10,
      SEL_CMP = 2'b11
   } ctl_sel_t;
endpackage : dio_pkg

//--- verif/dio_line_partner.sv
// far-side line model for one 8-line port
`timescale 1ns/1ps
`default_nettype none
module dio_line_partner (
   // block side and far device
   input wire logic [7:0] out_val,
   input wire logic [7:0] oe,
   input wire logic [7:0] ext,
   // resolved pin level
   output logic [7:0] pin
);
   // driven lines read back, released lines follow the far device
   assign pin = (oe & out_val) | (~oe & ext);
endmodule : dio_line_partner
`default_nettype wire

//--- verif/dio_checker_properties.sv
// port assertions for the digital i/o block
`timescale 1ns/1ps
`default_nettype none
module dio_checker (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // host register port
   input wire logic rd_stb,
   input wire logic wr_stb,
   input wire logic [8:0] addr,
   input wire logic [31:0] rd_data,
   // port lines
   input wire logic [7:0] bitwise_port_out,
   input wire logic [7:0] bitwise_port_oe,
   input wire logic [7:0] bytewide_port_out,
   input wire logic [7:0] bytewide_port_oe,
   // sampling and status
   input wire logic fixed_sample_tick,
   input wire logic prog_sample_tick,
   input wire logic digital_irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   byte_dir_whole_a: assert property (
      bytewide_port_oe == 8'h00 || bytewide_port_oe == 8'hff)
      else $error("byte port enables differ");
   irq_hold_a: assert property ($fell(digital_irq) |->
      $past(rd_stb || wr_stb) && $past(addr) == 9'h078)
      else $error("irq dropped without clear");
   irq_cause_a: assert property ($rose(digital_irq) |->
      $past(fixed_sample_tick || prog_sample_tick))
      else $error("irq rose without a sample tick");
   rd_hold_a: assert property (!$past(rd_stb) |-> $stable(rd_data))
      else $error("read data moved without a read");
   bit_out_wr_a: assert property (
      $changed(bitwise_port_out) |-> $past(wr_stb))
      else $error("bit port output moved without a write");
   bit_dir_wr_a: assert property ($changed(bitwise_port_oe) |->
      $past(wr_stb && addr == 9'h078))
      else $error("bit port direction moved without a write");
   byte_out_wr_a: assert property ($changed(bytewide_port_out) |->
      $past(wr_stb) && $past(addr) inside {9'h074, 9'h078})
      else $error("byte port output moved without a write");
   unmapped_zero_a: assert property (
      rd_stb && !(addr inside {9'h070, 9'h074, 9'h078, 9'h07c}) |=>
      rd_data == 32'h0)
      else $error("unmapped read not zero");
endmodule : dio_checker
bind digital_io_pattern_interrupt dio_checker chk_i (.ref_clk, .rst_b,
   .rd_stb, .wr_stb, .digital_irq, .fixed_sample_tick, .prog_sample_tick,
   .addr, .rd_data, .bitwise_port_out, .bitwise_port_oe, .bytewide_port_out,
   .bytewide_port_oe);
`default_nettype wire

//--- verif/digital_io_pattern_interrupt_tb_top.sv
// self-checking bench for the digital i/o block
`timescale 1ns/1ps
`default_nettype none
module digital_io_pattern_interrupt_tb_top;
   import dio_pkg::*;
   logic ref_clk = 1'b0, rst_b = 1'b0, rd_stb = 1'b0, wr_stb = 1'b0;
   logic fixed_sample_tick = 1'b0, prog_sample_tick = 1'b0, strobe_in = 1'b0;
   logic [8:0] addr = 9'h000;
   logic [31:0] wr_data = 32'h0, rd_data;
   logic [7:0] ext_bit = 8'ha5, ext_byte = 8'h5a, bitwise_port_in;
   logic [7:0] bytewide_port_in, bitwise_port_out, bitwise_port_oe;
   logic [7:0] bytewide_port_out, bytewide_port_oe;
   logic digital_irq;
   int failures = 0, num_checks = 0;
   always #50 ref_clk = ~ref_clk;
   digital_io_pattern_interrupt DUT (.ref_clk, .rst_b, .addr, .rd_stb,
      .wr_stb, .wr_data, .rd_data, .bitwise_port_in, .bitwise_port_out,
      .bitwise_port_oe, .bytewide_port_in, .bytewide_port_out,
      .bytewide_port_oe, .fixed_sample_tick, .prog_sample_tick, .strobe_in,
      .digital_irq);
   dio_line_partner bit_far (.out_val(bitwise_port_out),
      .oe(bitwise_port_oe), .ext(ext_bit), .pin(bitwise_port_in));
   dio_line_partner byte_far (.out_val(bytewide_port_out),
      .oe(bytewide_port_oe), .ext(ext_byte), .pin(bytewide_port_in));
   // ==========================================
   // access tasks
   task automatic chk(input string n, input logic [31:0] s, e);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      #1;
   endtask : wr
   // an unknown expectation means the read is only for its side effect
   task automatic rd(input logic [8:0] a, input logic [31:0] e = 'x);
      @(posedge ref_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      @(posedge ref_clk);
      #1;
      if (e !== 32'hx) chk("rd_data", rd_data, e);
   endtask : rd
   // prog picks which sample tick input pulses
   task automatic tick(input logic prog = 1'b0);
      @(posedge ref_clk);
      fixed_sample_tick <= !prog;
      prog_sample_tick <= prog;
      @(posedge ref_clk);
      fixed_sample_tick <= 1'b0;
      prog_sample_tick <= 1'b0;
      @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic final_report;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report
   // ==========================================
   // tests
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      #1 chk("outs", {bitwise_port_out, bitwise_port_oe, bytewide_port_out,
         bytewide_port_oe}, 32'h0);
      wr(9'h07c, 32'h01);
      wr(9'h078, 32'h0f);
      wr(9'h070, 32'hff);
      chk("bit_oe", bitwise_port_oe, 32'h0f);
      chk("bit_out", bitwise_port_out, 32'h0f);
      rd(9'h070, 32'haf);
      wr(9'h07c, 32'h02);
      wr(9'h078, 32'h01);
      wr(9'h070, 32'h00);
      rd(9'h070, 32'ha1);
      wr(9'h074, 32'h3c);
      rd(9'h074, 32'h5a);
      wr(9'h07c, 32'h06);
      wr(9'h074, 32'h3c);
      rd(9'h074, 32'h3c);
      chk("byte_oe", bytewide_port_oe, 32'hff);
      chk("byte_out", bytewide_port_out, 32'h3c);
      wr(9'h07c, 32'h1f);
      wr(9'h078, 32'ha0);
      tick();
      chk("irq", digital_irq, 32'h1);
      rd(9'h07c, 32'h5f);
      wr(9'h07c, 32'h1c);
      chk("irq", digital_irq, 32'h1);
      rd(9'h078);
      chk("irq", digital_irq, 32'h0);
      wr(9'h07c, 32'h17);
      tick();
      @(posedge ref_clk);
      ext_bit <= 8'h20;
      tick();
      chk("irq", digital_irq, 32'h1);
      rd(9'h078, 32'h21);
      @(posedge ref_clk);
      strobe_in <= 1'b1;
      @(posedge ref_clk);
      strobe_in <= 1'b0;
      rd(9'h07c, 32'hd7);
      wr(9'h07c, 32'h14);
      wr(9'h078, 32'h00);
      chk("reset", {bitwise_port_out, bitwise_port_oe, bytewide_port_out,
         digital_irq}, 32'h0);
      rd(9'h07c, 32'h10);
      chk("byte_oe", bytewide_port_oe, 32'h0);
      wr(9'h07c, 32'h3b);
      wr(9'h078, 32'h20);
      tick(1'b0);
      chk("irq", digital_irq, 32'h0);
      tick(1'b1);
      chk("irq", digital_irq, 32'h1);
      rd(9'h080, 32'h0);
      final_report();
   end
   // the tests need well under 50 us
   initial begin
      #200us;
      failures++;
      final_report();
   end
endmodule : digital_io_pattern_interrupt_tb_top
`default_nettype wire
